/* File: logic/epic_host.sv */
// Host controller that drives the eight-level priority interrupt core over its pins
//
// Notes on behaviour
// - A peripheral raises its request high and holds it until acknowledged.
// - The service routine writes an end-of-service command to clear in-service.
// - Exactly three acknowledge pulses per interrupt: opcode, then two vector bytes.
// - The first init word starts a sequence; no interrupts until it completes.
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`include "epic_defines.svh"

module epic_host (
   input wire logic sys_clk, // System clock, 25 MHz
   input wire logic rst_n, // Async reset
   input wire logic hsel, // AHB slave select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write flag
   input wire logic [2:0] hsize, // AHB size, word only
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB bus ready
   output logic hreadyout, // AHB slave ready
   output logic [31:0] hrdata, // AHB read data
   output logic hresp, // AHB response
   output logic chip_select_n, // Device chip select
   output logic write_strobe_n, // Device write strobe
   output logic read_strobe_n, // Device read strobe
   output logic word_select, // Device word select
   output logic acknowledge_strobe_n, // Device acknowledge
   output logic master_select, // Device role strap
   output logic [7:0] host_data_lines_o, // Data bus drive value
   output logic host_data_lines_oe, // Data bus drive enable
   input wire logic [7:0] host_data_lines_i, // Data bus level
   input wire logic interrupt_level // Device interrupt output
);
   import epic_pkg::*;

   localparam epic_core_t CORE_RST = '{state: ST_IDLE, cs_n: 1'b1, wr_n: 1'b1,
                                      rd_n: 1'b1, ack_n: 1'b1, default: '0};
   localparam logic [3:0] STROBE_LOAD = 4'(`EPIC_STROBE_CYC - 1);
   localparam logic [3:0] GAP_LOAD = 4'(`EPIC_GAP_CYC - 1);

   epic_core_t st_r;
   epic_core_t st_nxt;
   epic_regs_if rif ();

   // ****************************************
   // Register slave
   // ****************************************
   epic_ahb_regs u_regs (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .hresp(hresp),
      .rif(rif.regs)
   );

   assign rif.cmd_ready = (st_r.state == ST_IDLE);
   assign rif.busy = (st_r.state != ST_IDLE);
   assign rif.irq_level = st_r.int_s2;
   assign rif.vec_valid = st_r.vec_valid;
   assign rif.call_ok = (st_r.opcode == `EPIC_CALL_OPCODE);
   assign rif.opcode = st_r.opcode;
   assign rif.vec_addr = {st_r.vec_hi, st_r.vec_lo};
   assign rif.rd_byte = st_r.rd_byte;

   // ****************************************
   // Pin outputs
   // ****************************************
   assign chip_select_n = st_r.cs_n;
   assign write_strobe_n = st_r.wr_n;
   assign read_strobe_n = st_r.rd_n;
   assign word_select = st_r.ws;
   assign acknowledge_strobe_n = st_r.ack_n;
   assign master_select = rif.master_sel;
   assign host_data_lines_o = st_r.dout;
   assign host_data_lines_oe = st_r.doe;

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.int_s1 = interrupt_level;
      st_nxt.int_s2 = st_r.int_s1;
      st_nxt.din_s1 = host_data_lines_i;
      st_nxt.din_s2 = st_r.din_s1;
      if (rif.vec_clr)
         st_nxt.vec_valid = 1'b0;
      case (st_r.state)
         ST_IDLE:
         begin
            st_nxt.cnt = STROBE_LOAD;
            st_nxt.ack_idx = 2'h0;
            if (rif.cmd_valid)
            begin
               // Init words and end-of-service are plain writes chosen by software
               st_nxt.is_ack = 1'b0;
               st_nxt.cs_n = 1'b0;
               st_nxt.ws = rif.cmd_word[`EPIC_CMD_WS_BIT];
               if (rif.cmd_word[`EPIC_CMD_READ_BIT])
               begin
                  st_nxt.rd_n = 1'b0;
                  st_nxt.state = ST_RSTROBE;
               end
               else
               begin
                  st_nxt.wr_n = 1'b0;
                  st_nxt.dout = rif.cmd_word[7:0];
                  st_nxt.doe = 1'b1;
                  st_nxt.state = ST_WSTROBE;
               end
            end
            else if (rif.ack_en && st_r.int_s2)
            begin
               // Software enables answering only after initialization is done
               st_nxt.is_ack = 1'b1;
               st_nxt.ack_n = 1'b0;
               st_nxt.state = ST_ASTROBE;
            end
         end
         ST_WSTROBE, ST_RSTROBE, ST_ASTROBE:
         begin
            if (st_r.cnt == 4'h0)
            begin
               // Sample before releasing the strobe; the device stops driving after it
               if (st_r.state == ST_RSTROBE)
                  st_nxt.rd_byte = st_r.din_s2;
               if (st_r.state == ST_ASTROBE)
               begin
                  case (st_r.ack_idx)
                     2'h0: st_nxt.opcode = st_r.din_s2;
                     2'h1: st_nxt.vec_lo = st_r.din_s2;
                     default: st_nxt.vec_hi = st_r.din_s2;
                  endcase
               end
               st_nxt.cs_n = 1'b1;
               st_nxt.wr_n = 1'b1;
               st_nxt.rd_n = 1'b1;
               st_nxt.ack_n = 1'b1;
               st_nxt.doe = 1'b0;
               st_nxt.cnt = GAP_LOAD;
               st_nxt.state = ST_GAP;
            end
            else
               st_nxt.cnt = st_r.cnt - 4'h1;
         end
         ST_GAP:
         begin
            if (st_r.cnt != 4'h0)
               st_nxt.cnt = st_r.cnt - 4'h1;
            else if (st_r.is_ack && (st_r.ack_idx != 2'h2))
            begin
               st_nxt.ack_idx = st_r.ack_idx + 2'h1;
               st_nxt.ack_n = 1'b0;
               st_nxt.cnt = STROBE_LOAD;
               st_nxt.state = ST_ASTROBE;
            end
            else
            begin
               // A fresh vector wins over a clear in the same cycle
               if (st_r.is_ack)
                  st_nxt.vec_valid = 1'b1;
               st_nxt.state = ST_IDLE;
            end
         end
         default:
            st_nxt = CORE_RST;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= CORE_RST;
      else
         st_r <= st_nxt;
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   a_ack_width: assert property ($fell(st_r.ack_n) |-> !st_r.ack_n[*5] ##1 st_r.ack_n)
      else $error("acknowledge pulse width wrong");
   a_ack_second: assert property (($fell(st_r.ack_n) && st_r.ack_idx == 2'h0)
      |-> ##8 ($fell(st_r.ack_n) && st_r.ack_idx == 2'h1))
      else $error("second acknowledge pulse missing");
   a_ack_third: assert property (($fell(st_r.ack_n) && st_r.ack_idx == 2'h1)
      |-> ##8 ($fell(st_r.ack_n) && st_r.ack_idx == 2'h2))
      else $error("third acknowledge pulse missing");
   a_ack_release: assert property (($fell(st_r.ack_n) && st_r.ack_idx == 2'h2)
      |-> ##8 (st_r.state == ST_IDLE && st_r.vec_valid))
      else $error("vector not reported after third pulse");
   // The enable is judged in the idle cycle that decided to answer
   a_ack_enabled: assert property ($fell(st_r.ack_n) && st_r.ack_idx == 2'h0
      |-> $past(rif.ack_en))
      else $error("acknowledge issued while answering disabled");
   a_write_qual: assert property (!st_r.wr_n |-> !st_r.cs_n && st_r.doe)
      else $error("write strobe without select or data");
   a_read_qual: assert property (!st_r.rd_n |-> !st_r.cs_n && !st_r.doe)
      else $error("read strobe with bus driven or unselected");
   a_bus_release: assert property (!st_r.ack_n |-> !st_r.doe && st_r.cs_n)
      else $error("bus driven during acknowledge");
   a_strobe_excl: assert property ($onehot0({!st_r.wr_n, !st_r.rd_n, !st_r.ack_n}))
      else $error("strobes overlap");

endmodule : epic_host

/* File: logic/epic_defines.svh */
// Offsets, field positions, reset values and timing counts of the interrupt-core host
`ifndef EPIC_DEFINES_SVH
`define EPIC_DEFINES_SVH

// ****************************************
// Own register map (byte addresses)
// ****************************************
`define EPIC_REG_CMD 8'h00
`define EPIC_REG_CTRL 8'h04
`define EPIC_REG_STAT 8'h08
`define EPIC_REG_VEC 8'h0C
`define EPIC_REG_RDAT 8'h10

// ****************************************
// Field positions
// ****************************************
`define EPIC_CMD_WS_BIT 8
`define EPIC_CMD_READ_BIT 9
`define EPIC_CTRL_ACK_EN_BIT 0
`define EPIC_CTRL_MASTER_BIT 1
`define EPIC_STAT_BUSY_BIT 0
`define EPIC_STAT_IRQ_BIT 1
`define EPIC_STAT_VALID_BIT 2
`define EPIC_STAT_CALL_BIT 3

// ****************************************
// Reset values and constants
// ****************************************
`define EPIC_CTRL_ACK_EN_RST 1'b0
`define EPIC_CTRL_MASTER_RST 1'b1
`define EPIC_CALL_OPCODE 8'hCD

// ****************************************
// Timing
// ****************************************
`define EPIC_CLK_NS 40
`define EPIC_STROBE_NS 200
`define EPIC_GAP_NS 120
`define EPIC_STROBE_CYC ((`EPIC_STROBE_NS + `EPIC_CLK_NS - 1) / `EPIC_CLK_NS)
`define EPIC_GAP_CYC ((`EPIC_GAP_NS + `EPIC_CLK_NS - 1) / `EPIC_CLK_NS)

`endif

/* File: logic/epic_pkg.sv */
// Types shared by the interrupt-core host modules
package epic_pkg;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_WSTROBE = 5'h02,
      ST_RSTROBE = 5'h04,
      ST_ASTROBE = 5'h08,
      ST_GAP = 5'h10
   } epic_state_t;

   typedef struct packed {
      epic_state_t state;
      logic [3:0] cnt;
      logic is_ack;
      logic [1:0] ack_idx;
      logic cs_n;
      logic wr_n;
      logic rd_n;
      logic ack_n;
      logic ws;
      logic [7:0] dout;
      logic doe;
      logic [7:0] rd_byte;
      logic [7:0] opcode;
      logic [7:0] vec_lo;
      logic [7:0] vec_hi;
      logic vec_valid;
      logic int_s1;
      logic int_s2;
      logic [7:0] din_s1;
      logic [7:0] din_s2;
   } epic_core_t;

   typedef struct packed {
      logic ph_valid;
      logic ph_write;
      logic [7:0] ph_addr;
      logic [31:0] hrdata;
      logic ack_en;
      logic master_sel;
   } epic_slv_t;

endpackage : epic_pkg

/* File: logic/epic_regs_if.sv */
// Carrier between the register slave and the pin sequencer
interface epic_regs_if;
   logic cmd_valid;
   logic cmd_ready;
   logic [9:0] cmd_word;
   logic ack_en;
   logic master_sel;
   logic vec_clr;
   logic busy;
   logic irq_level;
   logic vec_valid;
   logic call_ok;
   logic [7:0] opcode;
   logic [15:0] vec_addr;
   logic [7:0] rd_byte;

   modport regs (
      output cmd_valid, cmd_word, ack_en, master_sel, vec_clr,
      input cmd_ready, busy, irq_level, vec_valid, call_ok, opcode, vec_addr, rd_byte
   );
   modport core (
      input cmd_valid, cmd_word, ack_en, master_sel, vec_clr,
      output cmd_ready, busy, irq_level, vec_valid, call_ok, opcode, vec_addr, rd_byte
   );
endinterface : epic_regs_if

/* File: logic/epic_ahb_regs.sv */
// AHB-Lite slave holding the host's own command, control and status registers
`include "epic_defines.svh"

module epic_ahb_regs (
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Async reset
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write flag
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic hreadyout, // Always ready
   output logic [31:0] hrdata, // Read data
   output logic hresp, // Always OKAY
   epic_regs_if.regs rif // Link to sequencer
);
   import epic_pkg::*;

   localparam epic_slv_t SLV_RST = '{ack_en: `EPIC_CTRL_ACK_EN_RST,
                                     master_sel: `EPIC_CTRL_MASTER_RST, default: '0};

   epic_slv_t st_r;
   epic_slv_t st_nxt;
   logic wr_phase;

   // ****************************************
   // Data-phase side effects
   // ****************************************
   // Commands are not queued: a command written while busy is dropped
   assign wr_phase = st_r.ph_valid && st_r.ph_write;
   assign rif.cmd_valid = wr_phase && (st_r.ph_addr == `EPIC_REG_CMD);
   assign rif.cmd_word = hwdata[9:0];
   assign rif.vec_clr = wr_phase && (st_r.ph_addr == `EPIC_REG_STAT)
                        && hwdata[`EPIC_STAT_VALID_BIT];
   assign rif.ack_en = st_r.ack_en;
   assign rif.master_sel = st_r.master_sel;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st_r.hrdata;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.ph_valid = hsel && htrans[1] && hready;
      st_nxt.ph_write = hwrite;
      st_nxt.ph_addr = {haddr[7:2], 2'b00};
      if (wr_phase && (st_r.ph_addr == `EPIC_REG_CTRL))
      begin
         st_nxt.ack_en = hwdata[`EPIC_CTRL_ACK_EN_BIT];
         st_nxt.master_sel = hwdata[`EPIC_CTRL_MASTER_BIT];
      end
      st_nxt.hrdata = 32'h0000_0000;
      if (hsel && htrans[1] && hready && !hwrite)
      begin
         case ({haddr[7:2], 2'b00})
            `EPIC_REG_CTRL:
               st_nxt.hrdata = {30'h0000_0000, st_r.master_sel, st_r.ack_en};
            `EPIC_REG_STAT:
               st_nxt.hrdata = {28'h000_0000, rif.call_ok, rif.vec_valid,
                                rif.irq_level, rif.busy};
            `EPIC_REG_VEC:
               st_nxt.hrdata = {8'h00, rif.vec_addr, rif.opcode};
            `EPIC_REG_RDAT:
               st_nxt.hrdata = {24'h00_0000, rif.rd_byte};
            default:
               st_nxt.hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= SLV_RST;
      else
         st_r <= st_nxt;
   end

endmodule : epic_ahb_regs

/* File: verification/epic_dev_model.sv */
// Behavioural model of the eight-level interrupt core seen at the host's pins
module epic_dev_model (
   input wire logic cs_n, // Chip select
   input wire logic wr_n, // Write strobe
   input wire logic rd_n, // Read strobe
   input wire logic ws, // Word select
   input wire logic ack_n, // Acknowledge
   input wire logic master_select, // Role strap
   input wire logic [7:0] req, // Requests
   input wire logic [7:0] bus_i, // Bus level
   output logic [7:0] bus_o, // Bus drive value
   output logic bus_oe, // Bus drive enable
   output logic cas_oe, // Cascade drive
   output logic int_o // Interrupt
);
   // ****
   // Latches and resolver
   // ****
   logic [7:0] arm = 8'hFF, in_service_latch = 8'h00, request_mask_latch = 8'h00, frz = 8'h00, hi_a = 8'h00, wd, ab;
   logic [15:0] va;
   logic [3:0] t;
   logic [2:0] a75 = 3'h0, lv;
   logic [1:0] n = 2'h0, step = 2'h0;
   logic rdy = 1'b0, f4 = 1'b0, one = 1'b1, rsel = 1'b0, fz = 1'b0, wa, wt = 1'b0;
   wire [7:0] pending_request_latch = fz ? frz : req & arm;
   // Fixed order, input 7 lowest
   function automatic logic [3:0] top(input logic [7:0] v);
      top = 4'h8;
      for (int i = 7; i >= 0; i--)
         if (v[i])
            top = 4'(i);
   endfunction : top
   assign int_o = rdy && top(pending_request_latch & ~request_mask_latch) < top(in_service_latch);
   assign cas_oe = master_select;
   assign bus_oe = !ack_n || (!cs_n && !rd_n);
   assign bus_o = !ack_n ? ab : ws ? request_mask_latch : rsel ? in_service_latch : pending_request_latch;
   always @(req)
      arm = arm | ~req;
   // Latch just after the strobe falls, so the release edge cannot race in a floating bus
   always @(negedge wr_n)
   begin
      #1;
      if (!cs_n)
      begin
         wd = bus_i;
         wa = ws;
         wt = 1'b1;
      end
   end
   // Command acted on at the end of the strobe, when the data is surely settled
   always @(posedge wr_n)
      if (wt)
      begin
         wt = 1'b0;
         if (!wa && wd[4])
         begin
            rdy = 1'b0;
            step = 2'h1;
            request_mask_latch = 8'h00;
            arm = ~req;
            rsel = 1'b0;
            f4 = wd[2];
            one = wd[1];
            a75 = wd[7:5];
         end
         else if (step == 2'h1)
         begin
            hi_a = wd;
            step = one ? 2'h0 : 2'h2;
            rdy = one;
         end
         else if (step == 2'h2)
         begin
            step = 2'h0;
            rdy = 1'b1;
         end
         else if (wa)
            request_mask_latch = wd;
         else if (wd == 8'h20)
            in_service_latch = in_service_latch & (in_service_latch - 8'h01);
         else if (wd[4:3] == 2'b01 && wd[1])
            rsel = wd[0];
      end
   always @(negedge ack_n)
   begin
      n = n + 2'h1;
      if (n == 2'h1)
      begin
         frz = req & arm;
         fz = 1'b1;
         ab = 8'hCD;
      end
      else if (n == 2'h2)
      begin
         t = top(frz & ~request_mask_latch);
         lv = t[2:0];
         va = f4 ? {hi_a, a75, lv, 2'b00} : {hi_a, a75[2:1], lv, 3'b000};
         ab = va[7:0];
      end
      else
         ab = va[15:8];
   end
   always @(posedge ack_n)
      if (n == 2'h3)
      begin
         in_service_latch[lv] = 1'b1;
         arm[lv] = ~req[lv];
         fz = 1'b0;
         n = 2'h0;
      end
endmodule : epic_dev_model

/* File: verification/tb_epic_host.sv */
// Self-checking bench for the interrupt-core host controller
`include "epic_defines.svh"
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin error_cnt++; $display("wrong value %s expected %h seen %h", nm, e, s); end end

module tb_epic_host;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] w1, w2; logic [2:0] lv; logic [15:0] v;} epic_row_t;
   epic_row_t rows [8] = '{'{8'h76, 8'h39, 3'h0, 16'h3960}, '{8'h76, 8'h39, 3'h5, 16'h3974},
      '{8'h12, 8'h00, 3'h1, 16'h0008}, '{8'h12, 8'h00, 3'h7, 16'h0038},
      '{8'hF2, 8'hAB, 3'h2, 16'hABD0}, '{8'hF2, 8'hAB, 3'h6, 16'hABF0},
      '{8'h16, 8'h80, 3'h3, 16'h800C}, '{8'h16, 8'h80, 3'h4, 16'h8010}};
   logic sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [7:0] req = 8'h00, flt = 8'h00, dev_o, host_o;
   logic hreadyout, hresp, cs_n, wr_n, rd_n, ws, ack_n, msel, host_oe, dev_oe, int_o;
   // Undriven bus shows a changing pattern so a stale value never passes
   wire [7:0] bus = host_oe ? host_o : dev_oe ? dev_o : flt;
   int error_cnt = 0, comparisons = 0, acks = 0;
   epic_host u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .chip_select_n(cs_n),
      .write_strobe_n(wr_n), .read_strobe_n(rd_n), .word_select(ws),
      .acknowledge_strobe_n(ack_n), .master_select(msel), .host_data_lines_o(host_o),
      .host_data_lines_oe(host_oe), .host_data_lines_i(bus), .interrupt_level(int_o));
   epic_dev_model u_dev (.cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .ws(ws), .ack_n(ack_n),
      .master_select(msel), .req(req), .bus_i(bus), .bus_o(dev_o), .bus_oe(dev_oe),
      .cas_oe(), .int_o(int_o));
   always #20 sys_clk = ~sys_clk;
   always @(negedge ack_n)
      acks++;
   always @(posedge sys_clk)
   begin
      flt <= flt + 8'h3B;
      if (rst_n)
      begin
         `CHK("bus clash", 1'b0, host_oe && dev_oe)
         if (!wr_n)
            `CHK("select on write", 1'b0, cs_n)
      end
   end
   // ****
   // Bus tasks
   // ****
   task automatic end_sim;
      if (error_cnt == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   task automatic phase;
      int n;
      logic r;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         rd = hrdata;
         r = hreadyout;
         @(posedge sys_clk);
         n++;
      end
      while (r !== 1'b1 && n < 20);
      if (r !== 1'b1)
      begin
         error_cnt++;
         end_sim();
      end
   endtask : phase
   task automatic bus_op(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      phase();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      phase();
   endtask : bus_op
   task automatic poll(input int b, input logic v);
      int n;
      n = 0;
      do
      begin
         bus_op(1'b0, `EPIC_REG_STAT, 32'h0);
         n++;
      end
      while (rd[b] !== v && n < 200);
      if (rd[b] !== v)
      begin
         error_cnt++;
         end_sim();
      end
   endtask : poll
   task automatic cmd(input logic a, input logic [7:0] d);
      bus_op(1'b1, `EPIC_REG_CMD, {22'h0, 1'b0, a, d});
      poll(`EPIC_STAT_BUSY_BIT, 1'b0);
   endtask : cmd
   task automatic sts(input logic a, input logic [7:0] e);
      bus_op(1'b1, `EPIC_REG_CMD, {22'h0, 1'b1, a, 8'h00});
      poll(`EPIC_STAT_BUSY_BIT, 1'b0);
      bus_op(1'b0, `EPIC_REG_RDAT, 32'h0);
      `CHK("status byte", {24'h0, e}, rd)
   endtask : sts
   task automatic irq(input logic e);
      repeat (4) @(posedge sys_clk);
      bus_op(1'b0, `EPIC_REG_STAT, 32'h0);
      `CHK("irq", e, rd[`EPIC_STAT_IRQ_BIT])
   endtask : irq
   task automatic ctrl(input logic m, input logic en);
      bus_op(1'b1, `EPIC_REG_CTRL, {30'h0, m, en});
   endtask : ctrl
   task automatic vec(input logic [15:0] e);
      int a0;
      a0 = acks;
      poll(`EPIC_STAT_VALID_BIT, 1'b1);
      `CHK("call", 1'b1, rd[`EPIC_STAT_CALL_BIT])
      bus_op(1'b0, `EPIC_REG_VEC, 32'h0);
      `CHK("vector", {8'h00, e, 8'hCD}, rd)
      `CHK("pulses", 3, acks - a0)
      bus_op(1'b1, `EPIC_REG_STAT, 32'h4);
   endtask : vec
   // ****
   // Main sequence
   // ****
   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      `CHK("idle pins", 5'h1F, {cs_n, wr_n, rd_n, ack_n, msel})
      `CHK("oe", 1'b0, host_oe)
      bus_op(1'b0, `EPIC_REG_CTRL, 32'h0);
      `CHK("ctrl", 32'h2, rd)
      bus_op(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      ctrl(1'b0, 1'b0);
      @(negedge sys_clk);
      `CHK("slave role", 1'b0, msel)
      for (int i = 0; i < 8; i++)
      begin
         ctrl(1'b1, 1'b0);
         cmd(1'b0, rows[i].w1);
         cmd(1'b1, rows[i].w2);
         req[rows[i].lv] <= 1'b1;
         ctrl(1'b1, 1'b1);
         vec(rows[i].v);
         req[rows[i].lv] <= 1'b0;
         cmd(1'b0, 8'h20);
      end
      req[2] <= 1'b1;
      ctrl(1'b1, 1'b1);
      vec(16'h8008);
      ctrl(1'b1, 1'b0);
      cmd(1'b0, 8'h20);
      sts(1'b0, 8'h00);
      irq(1'b0);
      req[2] <= 1'b0;
      @(posedge sys_clk);
      req[2] <= 1'b1;
      sts(1'b0, 8'h04);
      irq(1'b1);
      cmd(1'b1, 8'h04);
      irq(1'b0);
      sts(1'b0, 8'h04);
      sts(1'b1, 8'h04);
      cmd(1'b1, 8'h00);
      irq(1'b1);
      req[5] <= 1'b1;
      ctrl(1'b1, 1'b1);
      vec(16'h8008);
      irq(1'b0);
      req[1] <= 1'b1;
      vec(16'h8004);
      cmd(1'b0, 8'h20);
      irq(1'b0);
      ctrl(1'b1, 1'b0);
      cmd(1'b0, 8'h20);
      ctrl(1'b1, 1'b1);
      vec(16'h8014);
      cmd(1'b0, 8'h20);
      ctrl(1'b1, 1'b0);
      req <= 8'h40;
      cmd(1'b1, 8'h40);
      cmd(1'b0, 8'h16);
      cmd(1'b1, 8'h80);
      sts(1'b1, 8'h00);
      irq(1'b0);
      cmd(1'b0, 8'h16);
      req <= 8'h00;
      @(posedge sys_clk);
      req <= 8'h40;
      irq(1'b0);
      cmd(1'b1, 8'h80);
      irq(1'b1);
      ctrl(1'b0, 1'b0);
      rst_n <= 1'b0;
      @(posedge sys_clk);
      `CHK("reset pins", 5'h1F, {cs_n, wr_n, rd_n, ack_n, msel})
      `CHK("reset oe", 1'b0, host_oe)
      rst_n <= 1'b1;
      bus_op(1'b0, `EPIC_REG_CTRL, 32'h0);
      `CHK("reset ctrl", 32'h2, rd)
      end_sim();
   end
endmodule : tb_epic_host
